// File: logic/flic_pkg.sv
// Constants shared by the four-level interrupt controller files.
// Assumes one 20 MHz system clock and a 32-bit AHB-Lite register bus.
package flic_pkg;
  localparam int NSRC  = 15;
  localparam int NFLAG = 16;
  localparam int NLVL  = 4;
  localparam int DW    = 32;
  localparam int NEVT  = 3;

  // Byte offsets of the register map
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_FLAG_SET = 8'h04;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h08;
  localparam logic [7:0] OFS_EN_A     = 8'h10;
  localparam logic [7:0] OFS_EN_B     = 8'h14;
  localparam logic [7:0] OFS_SVC      = 8'h20;
  localparam logic [7:0] OFS_EVT      = 8'h24;
  localparam logic [7:0] OFS_MASK     = 8'h28;
  localparam logic [7:0] OFS_LP_A     = 8'hb8;
  localparam logic [7:0] OFS_LP_B     = 8'hbc;
  localparam logic [7:0] OFS_HP_A     = 8'hc0;
  localparam logic [7:0] OFS_HP_B     = 8'hc4;

  // Field positions
  localparam int GLB_BIT      = 7;
  localparam int ADC_SRC      = 6;
  localparam int WORD_OVF     = 14;
  localparam int BYTE_OVF     = 15;
  localparam int HTRANS_ACT   = 1;
  localparam int SVC_REQ_BIT  = 4;
  localparam int SVC_LVL_LSB  = 8;
  localparam int SVC_VEC_LSB  = 16;
  localparam int EV_GRANT     = 0;
  localparam int EV_PREEMPT   = 1;
  localparam int EV_SPUR      = 2;
  localparam logic [15:0] TMR2_FLAG_MASK = 16'hff80;

  // Vector of each source, indexed in flag order
  localparam logic [15:0] VEC_ADDR [NSRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0053,
    16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h005b, 16'h0063, 16'h006b, 16'h0073};

  // Polling rank within a level, 0 polled first
  localparam logic [3:0] POLL_RANK [NSRC] = '{
    4'h0, 4'h3, 4'h6, 4'h9, 4'hc, 4'h1, 4'h2,
    4'h4, 4'h7, 4'ha, 4'hd, 4'h5, 4'h8, 4'hb, 4'he};
endpackage

// File: logic/flic_flag_cell.sv
// One request flag: set by hardware or software, cleared by software.
// Assumes set and clear pulses come from logic on the same clock.
module flic_flag_cell #(
  parameter bit SW_SET_OK = 1'b1
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic hw_set,
  input  wire logic sw_set,
  input  wire logic sw_clr,
  output logic      flag
);
  typedef struct packed {
    logic flag;
  } flic_cell_t;

  flic_cell_t s_q;
  flic_cell_t s_d;

  // Set wins over a clear in the same cycle
  always_comb begin
    s_d      = s_q;
    s_d.flag = (s_q.flag & ~sw_clr) | hw_set | (sw_set & SW_SET_OK);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;
endmodule

// File: logic/flic_top.sv
// Four-level nested interrupt controller with an AHB-Lite register slave.
// Assumes flag set inputs are one-cycle pulses from peripherals on hclk,
// and a CPU core that pulses ack to take a vector and reti on return.
//
// Notes on behaviour
// - Fifteen sources, each at one of four levels
// - Timer two gives eight requests, overflow ORed
// - Capture inputs and compare matches set flags
// - Byte and word overflow set separate flags
// - Timer two flags cleared only by software
// - Conversion-done flag set on result, software clears
// - Status load sets the serial-two flag
// - Software cannot set the conversion-done flag
// - Other flags set and cleared by software
// - Per-source enables plus one global enable
// - Enable bit zero disables, one enables
// - High and low bit form level
// - Grant only above every in-service level
// - Higher level preempts, lower resumes after return
// - Fixed polling order breaks ties in level
// - Vectors eight bytes apart from 0003h
// - First low priority register at b8h
module flic_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext0_req,
  input  wire logic        ext1_req,
  input  wire logic        timer0_ovf,
  input  wire logic        timer1_ovf,
  input  wire logic        uart_req,
  input  wire logic        serial_two_status_load,
  input  wire logic        conv_done,
  input  wire logic [3:0]  capture_in,
  input  wire logic [2:0]  compare_match,
  input  wire logic        timer_word_ovf,
  input  wire logic        timer_byte_ovf,
  output logic             cpu_irq_req,
  output logic [15:0]      cpu_vector,
  output logic [1:0]       cpu_level,
  input  wire logic        cpu_ack,
  input  wire logic        cpu_reti,
  output logic             irq_out
);
  typedef struct packed {
    logic                     hready;
    logic                     hresp;
    logic [31:0]              hrdata;
    logic                     rd;
    logic                     wr;
    logic [7:0]               addr;
    logic [7:0]               source_enable_a;
    logic [7:0]               source_enable_b;
    logic [6:0]               low_priority_select_a;
    logic [7:0]               low_priority_select_b;
    logic [6:0]               high_priority_select_a;
    logic [7:0]               high_priority_select_b;
    logic [flic_pkg::NLVL-1:0] insvc;
    logic                     req;
    logic [15:0]              vec;
    logic [1:0]               lvl;
    logic [flic_pkg::NEVT-1:0] evt;
    logic [flic_pkg::NEVT-1:0] mask;
    logic                     irq;
  } flic_state_t;

  flic_state_t                 s_q;
  flic_state_t                 s_d;
  logic [flic_pkg::NFLAG-1:0]  hw_set;
  logic [flic_pkg::NFLAG-1:0]  sw_set;
  logic [flic_pkg::NFLAG-1:0]  sw_clr;
  logic [flic_pkg::NFLAG-1:0]  flag_w;
  logic [flic_pkg::NSRC-1:0]   req_src;
  logic [flic_pkg::NSRC-1:0]   enable_all;
  logic [flic_pkg::NSRC-1:0]   lo_all;
  logic [flic_pkg::NSRC-1:0]   hi_all;
  logic [flic_pkg::NSRC-1:0]   pend;
  logic [flic_pkg::NEVT-1:0]   evt_new;
  logic [flic_pkg::NEVT-1:0]   evt_w1c;
  logic [31:0]                 rd_mux;

  // Flag order: ext0, tmr0, ext1, tmr1, uart, i2c, adc, cap0-3, cmp0-2, word, byte
  assign hw_set = {timer_byte_ovf, timer_word_ovf, compare_match, capture_in,
                   conv_done, serial_two_status_load, uart_req, timer1_ovf,
                   ext1_req, timer0_ovf, ext0_req};

  // Converter flag refuses software sets; no cell ever self-clears
  for (genvar k = 0; k < flic_pkg::NFLAG; k++) begin : g_flag
    flic_flag_cell #(
      .SW_SET_OK (k != flic_pkg::ADC_SRC)
    ) u_cell (
      .hclk    (hclk),
      .hresetn (hresetn),
      .hw_set  (hw_set[k]),
      .sw_set  (sw_set[k]),
      .sw_clr  (sw_clr[k]),
      .flag    (flag_w[k])
    );
  end

  // Two overflow flags share one request line
  assign req_src = {flag_w[flic_pkg::WORD_OVF] | flag_w[flic_pkg::BYTE_OVF],
                    flag_w[flic_pkg::WORD_OVF-1:0]};
  assign enable_all = {s_q.source_enable_b, s_q.source_enable_a[flic_pkg::GLB_BIT-1:0]};
  assign lo_all     = {s_q.low_priority_select_b, s_q.low_priority_select_a};
  assign hi_all     = {s_q.high_priority_select_b, s_q.high_priority_select_a};
  // Request stays up while flag set and enabled
  assign pend = req_src & enable_all & {flic_pkg::NSRC{s_q.source_enable_a[flic_pkg::GLB_BIT]}};

  // Read data, sampled one cycle after the address phase
  always_comb begin
    rd_mux = '0;
    case (s_q.addr)
      flic_pkg::OFS_FLAGS: rd_mux = 32'(flag_w);
      flic_pkg::OFS_EN_A:  rd_mux = 32'(s_q.source_enable_a);
      flic_pkg::OFS_EN_B:  rd_mux = 32'(s_q.source_enable_b);
      flic_pkg::OFS_LP_A:  rd_mux = 32'(s_q.low_priority_select_a);
      flic_pkg::OFS_LP_B:  rd_mux = 32'(s_q.low_priority_select_b);
      flic_pkg::OFS_HP_A:  rd_mux = 32'(s_q.high_priority_select_a);
      flic_pkg::OFS_HP_B:  rd_mux = 32'(s_q.high_priority_select_b);
      flic_pkg::OFS_EVT:   rd_mux = 32'(s_q.evt);
      flic_pkg::OFS_MASK:  rd_mux = 32'(s_q.mask);
      flic_pkg::OFS_SVC: begin
        rd_mux[flic_pkg::NLVL-1:0]                  = s_q.insvc;
        rd_mux[flic_pkg::SVC_REQ_BIT]               = s_q.req;
        rd_mux[flic_pkg::SVC_LVL_LSB +: 2]          = s_q.lvl;
        rd_mux[flic_pkg::SVC_VEC_LSB +: 16]         = s_q.vec;
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    logic [flic_pkg::NLVL-1:0] insvc_n;
    logic                      found;
    logic [1:0]                best_lvl;
    logic [3:0]                best_rank;
    logic [3:0]                best_idx;
    logic [1:0]                lvl_i;
    logic                      any_n;
    logic [1:0]                top_n;
    logic [1:0]                top_q;
    insvc_n   = s_q.insvc;
    found     = 1'b0;
    best_lvl  = '0;
    best_rank = '0;
    best_idx  = '0;
    lvl_i     = '0;
    any_n     = 1'b0;
    top_n     = '0;
    top_q     = '0;
    s_d       = s_q;
    sw_set    = '0;
    sw_clr    = '0;
    evt_new   = '0;
    evt_w1c   = '0;

    // Bus slave: writes take no wait, reads take one
    s_d.hready = 1'b1;
    s_d.hresp  = 1'b0;
    s_d.rd     = 1'b0;
    s_d.wr     = 1'b0;
    if (s_q.rd) begin
      s_d.hrdata = rd_mux;
    end
    if (hsel && hready && htrans[flic_pkg::HTRANS_ACT]) begin
      s_d.addr = haddr[7:0];
      s_d.wr   = hwrite;
      s_d.rd   = !hwrite;
      if (!hwrite) begin
        s_d.hready = 1'b0;
      end
    end
    if (s_q.wr) begin
      case (s_q.addr)
        flic_pkg::OFS_FLAG_SET: sw_set = hwdata[flic_pkg::NFLAG-1:0];
        flic_pkg::OFS_FLAG_CLR: sw_clr = hwdata[flic_pkg::NFLAG-1:0];
        flic_pkg::OFS_EN_A:     s_d.source_enable_a = hwdata[7:0];
        flic_pkg::OFS_EN_B:     s_d.source_enable_b = hwdata[7:0];
        flic_pkg::OFS_LP_A:     s_d.low_priority_select_a = hwdata[6:0];
        flic_pkg::OFS_LP_B:     s_d.low_priority_select_b = hwdata[7:0];
        flic_pkg::OFS_HP_A:     s_d.high_priority_select_a = hwdata[6:0];
        flic_pkg::OFS_HP_B:     s_d.high_priority_select_b = hwdata[7:0];
        flic_pkg::OFS_EVT:      evt_w1c = hwdata[flic_pkg::NEVT-1:0];
        flic_pkg::OFS_MASK:     s_d.mask = hwdata[flic_pkg::NEVT-1:0];
        default: ;
      endcase
    end

    // In-service stack, one bit per level
    for (int l = 0; l < flic_pkg::NLVL; l++) begin
      if (s_q.insvc[l]) begin
        top_q = 2'(l);
      end
    end
    if (cpu_ack && s_q.req) begin
      insvc_n[s_q.lvl]          = 1'b1;
      evt_new[flic_pkg::EV_GRANT] = 1'b1;
      if (s_q.insvc != '0) begin
        evt_new[flic_pkg::EV_PREEMPT] = 1'b1;
      end
    end else if (cpu_reti) begin
      if (s_q.insvc == '0) begin
        evt_new[flic_pkg::EV_SPUR] = 1'b1;
      end else begin
        insvc_n[top_q] = 1'b0;
      end
    end
    s_d.insvc = insvc_n;

    // Highest level wins, then lowest polling rank
    for (int i = 0; i < flic_pkg::NSRC; i++) begin
      lvl_i = {hi_all[i], lo_all[i]};
      if (pend[i] && (!found || lvl_i > best_lvl ||
          (lvl_i == best_lvl && flic_pkg::POLL_RANK[i] < best_rank))) begin
        found     = 1'b1;
        best_lvl  = lvl_i;
        best_rank = flic_pkg::POLL_RANK[i];
        best_idx  = 4'(i);
      end
    end
    for (int l = 0; l < flic_pkg::NLVL; l++) begin
      if (insvc_n[l]) begin
        any_n = 1'b1;
        top_n = 2'(l);
      end
    end
    // Judged against the stack after this edge, so no stale grant
    s_d.req = found && (!any_n || best_lvl > top_n);
    if (found) begin
      s_d.vec = flic_pkg::VEC_ADDR[best_idx];
      s_d.lvl = best_lvl;
    end

    // Sticky events, set wins over write-one-to-clear
    s_d.evt = (s_q.evt & ~evt_w1c) | evt_new;
    s_d.irq = |(s_d.evt & s_d.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q        <= '0;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout   = s_q.hready;
  assign hresp       = s_q.hresp;
  assign hrdata      = s_q.hrdata;
  assign cpu_irq_req = s_q.req;
  assign cpu_vector  = s_q.vec;
  assign cpu_level   = s_q.lvl;
  assign irq_out     = s_q.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_HW_CAPTURE: assert property (capture_in[0] |=> flag_w[7])
    else $error("capture did not set its flag");
  AST_TMR2_STICKY: assert property (
    ~|($past(flag_w) & ~$past(sw_clr) & ~flag_w & flic_pkg::TMR2_FLAG_MASK))
    else $error("timer two flag cleared without software");
  AST_ADC_NO_SET: assert property (
    sw_set[flic_pkg::ADC_SRC] && !conv_done && !flag_w[flic_pkg::ADC_SRC]
    |=> !flag_w[flic_pkg::ADC_SRC])
    else $error("software set the conversion flag");
  AST_SW_SET: assert property (sw_set[0] |=> flag_w[0])
    else $error("software set lost");
  AST_SW_CLR: assert property (sw_clr[1] && !timer0_ovf |=> !flag_w[1])
    else $error("software clear lost");
  AST_GLOBAL: assert property ($rose(cpu_irq_req) |-> $past(s_q.source_enable_a[flic_pkg::GLB_BIT]))
    else $error("request raised while globally disabled");
  AST_LEVEL_GATE: assert property (cpu_irq_req |-> (s_q.insvc >> cpu_level) == 4'h0)
    else $error("request not above every level in service");
  AST_NEST_KEEP: assert property (
    cpu_ack && cpu_irq_req |=> ((s_q.insvc & $past(s_q.insvc)) == $past(s_q.insvc))
    && (s_q.insvc != $past(s_q.insvc)))
    else $error("preemption lost the interrupted level");
  AST_RETI_POP: assert property (
    cpu_reti && !cpu_ack && s_q.insvc != 4'h0
    |=> $countones(s_q.insvc) + 1 == $countones($past(s_q.insvc)))
    else $error("return did not release exactly one level");
  AST_VEC_STEP: assert property (
    cpu_irq_req |-> cpu_vector[2:0] == 3'h3 && cpu_vector <= 16'h0073)
    else $error("vector off the eight-byte grid");
  AST_READ_WAIT: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  AST_WRITE_NOWAIT: assert property (
    hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write data phase stalled");

  // Flag set, hold and clear paths and the overflow request, each checked one edge later
  AST_WORD_OVF: assert property (
    timer_word_ovf |=> flag_w[flic_pkg::WORD_OVF])
    else $error("word overflow did not set its flag");
  AST_BYTE_OVF: assert property (
    timer_byte_ovf |=> flag_w[flic_pkg::BYTE_OVF])
    else $error("byte overflow did not set its flag");
  AST_CMP_SET: assert property (
    compare_match[2] |=> flag_w[13])
    else $error("compare match did not set its flag");
  AST_ADC_SET: assert property (
    conv_done |=> flag_w[flic_pkg::ADC_SRC])
    else $error("conversion done did not set its flag");
  AST_ADC_STICKY: assert property (
    flag_w[flic_pkg::ADC_SRC] && !sw_clr[flic_pkg::ADC_SRC] |=> flag_w[flic_pkg::ADC_SRC])
    else $error("conversion flag cleared without software");
  AST_ADC_CLR: assert property (
    sw_clr[flic_pkg::ADC_SRC] && !conv_done |=> !flag_w[flic_pkg::ADC_SRC])
    else $error("software clear of the conversion flag lost");
  AST_I2C_SET: assert property (
    serial_two_status_load |=> flag_w[5])
    else $error("status load did not set the serial flag");
  AST_OVF_REQ: assert property (
    flag_w[flic_pkg::BYTE_OVF] && enable_all[flic_pkg::NSRC-1] && s_q.source_enable_a[flic_pkg::GLB_BIT]
    && s_q.insvc == 4'h0 && !cpu_ack |=> cpu_irq_req)
    else $error("byte overflow alone raised no request");

  // Event and request bookkeeping around ack and return
  AST_GRANT_EVT: assert property (
    cpu_ack && cpu_irq_req |=> s_q.evt[flic_pkg::EV_GRANT])
    else $error("grant event not recorded");
  AST_PREEMPT_EVT: assert property (
    cpu_ack && cpu_irq_req && s_q.insvc != 4'h0 |=> s_q.evt[flic_pkg::EV_PREEMPT])
    else $error("preemption event not recorded");
  AST_SPUR_EVT: assert property (
    cpu_reti && !cpu_ack && s_q.insvc == 4'h0 |=> s_q.evt[flic_pkg::EV_SPUR])
    else $error("return with nothing in service not recorded");
  AST_REQ_ABOVE: assert property (
    cpu_ack && cpu_irq_req |=> !cpu_irq_req || cpu_level > $past(cpu_level))
    else $error("request at or below the level just taken");
  AST_LOW_RESUMES: assert property (
    cpu_reti && !cpu_ack && s_q.insvc[1] && s_q.insvc[3:2] != 2'b00 |=> s_q.insvc[1])
    else $error("return dropped the preempted lower level");
  AST_IRQ_OUT: assert property (
    irq_out == (|(s_q.evt & s_q.mask)))
    else $error("interrupt output disagrees with status and mask");
endmodule

// File: testbench/flic_cpu_model.sv
// CPU core stand-in: takes a vector after a set delay, returns on command.
// Assumes the controller's cpu_* ports on the same hclk.
module flic_cpu_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       cpu_irq_req,
  input  wire logic [3:0] ack_dly,
  input  wire logic       ret_cmd,
  output logic            cpu_ack,
  output logic            cpu_reti
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  logic [2:0] hold_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q   <= 4'h0;
      hold_q   <= 3'h0;
      cpu_ack  <= 1'b0;
      cpu_reti <= 1'b0;
    end else begin
      cpu_ack  <= 1'b0;
      cpu_reti <= ret_cmd; // Return only when the bench says
      if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end else if (cpu_irq_req && wait_q == ack_dly) begin
        cpu_ack <= 1'b1; // Take the vector
        hold_q  <= 3'h4; // Request needs a few edges to fall
        wait_q  <= 4'h0;
      end else if (cpu_irq_req) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// File: testbench/flic_top_tb_top.sv
// Self-checking bench for the interrupt controller.
// Assumes the design's AHB-Lite slave answers reads with one wait state.
module flic_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] VEC [16] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0053,
    16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h005b, 16'h0063, 16'h006b, 16'h0073, 16'h0073};
  localparam int ORD [15] = '{0, 5, 6, 1, 7, 11, 2, 8, 12, 3, 9, 13, 4, 10, 14};
  logic        hclk, hresetn, hsel, hwrite, ret_cmd, rd_ph;
  logic        hreadyout, hresp, cpu_irq_req, cpu_ack, cpu_reti, irq_out;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [15:0] hw, cpu_vector;
  logic [1:0]  htrans, cpu_level;
  logic [2:0]  hsize;
  logic [3:0]  ack_dly;
  int          n_errors, samples_checked, n_acks, seed;
  logic [31:0] exp_rd [$];
  logic [17:0] exp_vec [$];

  flic_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext0_req(hw[0]), .timer0_ovf(hw[1]), .ext1_req(hw[2]), .timer1_ovf(hw[3]), .uart_req(hw[4]),
    .serial_two_status_load(hw[5]), .conv_done(hw[6]), .capture_in(hw[10:7]), .compare_match(hw[13:11]),
    .timer_word_ovf(hw[14]), .timer_byte_ovf(hw[15]), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .irq_out(irq_out));
  flic_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .cpu_irq_req(cpu_irq_req), .ack_dly(ack_dly),
    .ret_cmd(ret_cmd), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic note(input bit ok, input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    note(g === e, nm, e, g);
  endtask
  task automatic chk_vec(input logic [17:0] e, input logic [17:0] g);
    note(g === e, "level_vector", {14'h0, e}, {14'h0, g});
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    note(g === e, nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded wait; a hung bus ends the run as a failure
  task automatic wait_rdy();
    for (int i = 0; i < 64; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_errors++;
    summarize();
  endtask
  task automatic wait_acks(input int n);
    for (int i = 0; i < 400; i++) begin
      if (n_acks >= n) return;
      @(posedge hclk);
    end
    n_errors++;
    summarize();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    rd_ph  <= !wr;
    if (!wr) exp_rd.push_back(e);
    wait_rdy();
    rd_ph <= 1'b0;
  endtask
  task automatic pulse(input logic [15:0] f);
    hw <= f;
    @(posedge hclk);
    hw <= 16'h0;
    @(posedge hclk);
  endtask
  task automatic reti();
    ret_cmd <= 1'b1;
    @(posedge hclk);
    ret_cmd <= 1'b0;
    @(posedge hclk);
  endtask

  // Result watcher: oldest note against what appears
  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      chk_word("hrdata", exp_rd.size() ? exp_rd.pop_front() : 'x, hrdata);
      chk_bit("hresp", 1'b0, hresp);
    end
    if (cpu_ack === 1'b1 && cpu_irq_req === 1'b1) begin
      n_acks++;
      chk_vec(exp_vec.size() ? exp_vec.pop_front() : 'x, {cpu_level, cpu_vector});
    end
  end

  initial begin
    seed = 32'h85165fb4;
    {hresetn, hsel, hwrite, ret_cmd, rd_ph, htrans, haddr, hwdata, hw, ack_dly} <= '0;
    hsize <= 3'b010;
    tick(20);
    hresetn <= 1'b1;
    tick(1);
    bus(0, 8'h10, 0, 0);
    bus(0, 8'hb8, 0, 0);
    bus(0, 8'h30, 0, 0);
    v = $random(seed);
    bus(1, 8'hb8, v, 0);
    bus(0, 8'hb8, 0, {25'h0, v[6:0]});
    bus(1, 8'hb8, 0, 0);
    bus(1, 8'h04, 32'hffff, 0);
    bus(0, 8'h00, 0, 32'hffbf);
    bus(1, 8'h08, 32'hffff, 0);
    bus(0, 8'h00, 0, 0);
    pulse(16'hffff);
    bus(0, 8'h00, 0, 32'hffff);
    for (int k = 0; k < 15; k++) exp_vec.push_back({2'b00, VEC[ORD[k]]});
    ack_dly <= 4'($unsigned($random(seed)) % 4);
    bus(1, 8'h14, 32'hff, 0);
    bus(1, 8'h10, 32'hff, 0);
    for (int k = 0; k < 15; k++) begin
      wait_acks(k + 1);
      bus(1, 8'h08, (ORD[k] == 14) ? 32'hc000 : (32'h1 << ORD[k]), 0);
      reti();
    end
    bus(0, 8'h00, 0, 0);
    exp_vec.push_back({2'b00, 16'h003b});
    exp_vec.push_back({2'b00, 16'h003b});
    pulse(16'h0100);
    wait_acks(16);
    reti();
    wait_acks(17);
    bus(1, 8'h08, 32'h100, 0);
    reti();
    bus(1, 8'hb8, 32'h05, 0);
    bus(1, 8'hc0, 32'h06, 0);
    bus(1, 8'h28, 32'h02, 0);
    exp_vec.push_back({2'b01, 16'h0003});
    exp_vec.push_back({2'b10, 16'h000b});
    exp_vec.push_back({2'b11, 16'h0013});
    exp_vec.push_back({2'b00, 16'h0023});
    pulse(16'h0001);
    wait_acks(18);
    bus(1, 8'h08, 32'h1, 0);
    pulse(16'h0010);
    tick(10);
    chk_bit("cpu_irq_req", 1'b0, cpu_irq_req);
    pulse(16'h0002);
    wait_acks(19);
    bus(1, 8'h08, 32'h2, 0);
    pulse(16'h0004);
    wait_acks(20);
    bus(1, 8'h08, 32'h4, 0);
    chk_bit("irq_out", 1'b1, irq_out);
    bus(0, 8'h24, 0, 32'h3);
    bus(1, 8'h24, 32'h3, 0);
    tick(2);
    chk_bit("irq_out", 1'b0, irq_out);
    reti();
    reti();
    tick(4);
    chk_bit("cpu_irq_req", 1'b0, cpu_irq_req);
    reti();
    wait_acks(21);
    bus(1, 8'h08, 32'h10, 0);
    reti();
    reti();
    bus(1, 8'h28, 32'h04, 0);
    bus(0, 8'h24, 0, 32'h5);
    chk_bit("irq_out", 1'b1, irq_out);
    bus(1, 8'h24, 32'h5, 0);
    tick(2);
    chk_bit("irq_out", 1'b0, irq_out);
    exp_vec.push_back({2'b01, 16'h0003});
    bus(1, 8'h10, 32'h01, 0);
    pulse(16'h0001);
    tick(8);
    chk_bit("cpu_irq_req", 1'b0, cpu_irq_req);
    bus(1, 8'h10, 32'h80, 0);
    tick(4);
    chk_bit("cpu_irq_req", 1'b0, cpu_irq_req);
    bus(1, 8'h10, 32'h81, 0);
    wait_acks(22);
    bus(1, 8'h08, 32'h1, 0);
    reti();
    bus(1, 8'hbc, 32'h08, 0);
    bus(1, 8'hc4, 32'h08, 0);
    bus(0, 8'hbc, 0, 32'h08);
    bus(0, 8'hc4, 0, 32'h08);
    exp_vec.push_back({2'b11, 16'h004b});
    exp_vec.push_back({2'b01, 16'h0003});
    pulse(16'h0401);
    wait_acks(23);
    bus(1, 8'h08, 32'h400, 0);
    reti();
    wait_acks(24);
    bus(0, 8'h20, 0, 32'h00030102);
    bus(1, 8'h08, 32'h1, 0);
    reti();
    tick(5);
    chk_word("vectors_left", 32'h0, 32'(exp_vec.size()));
    summarize();
  end
endmodule
